/* design/tcx_timer_ctrl.sv */
// dual timer/counter with external interrupt flags, wishbone slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module tcx_timer_ctrl
    import tcx_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire tcx_wb_req_t wb_i,
    output tcx_wb_rsp_t      wb_o,
    // external pins
    input  wire logic        ext_irq0_pin_i,
    input  wire logic        ext_irq1_pin_i,
    input  wire logic        count_pin_zero_i,
    input  wire logic        count_pin_one_i,
    // interrupt vectoring and requests
    input  wire logic [3:0]  vector_ack_i,
    output logic      [3:0]  int_req_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // timer step for modes 00..10; split code holds the count
    // ------------------------------------------------------------------
    function automatic logic [16:0] tcx_step(input tcx_mode_t m,
                                             input logic [7:0] tl,
                                             input logic [7:0] th);
        logic [13:0] s13;
        logic [16:0] s17;
        logic [16:0] r;
        s13 = {1'b0, th, tl[4:0]} + 14'h0001;
        s17 = {1'b0, th, tl} + 17'h0_0001;
        r   = {1'b0, th, tl};
        unique case (m)
            TCX_M13: begin
                r = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
            end
            TCX_M16: begin
                r = s17;
            end
            TCX_RLD: begin
                if (tl == 8'hff) begin
                    r = {1'b1, th, th};
                end else begin
                    r = {1'b0, th, tl + 8'h01};
                end
            end
            TCX_SPLIT: begin
                r = {1'b0, th, tl};
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] trun_q;
    logic [7:0] timer_mode_select_q;
    logic [7:0] tl0_q, th0_q, tl1_q, th1_q;
    logic [3:0] sts_q, en_q;
    logic       ack_q, irq_q;
    logic [7:0] rdat_q;
    logic       x0_prev_q, x1_prev_q, c0_prev_q, c1_prev_q;

    logic [7:0]  tl0_d, th0_d, tl1_d, th1_d;
    logic        tf0_set, tf1_set, ie0_set, ie1_set;
    logic [16:0] st0, st1;
    logic        run0, run1, tick0, tick1;
    logic [3:0]  ev;
    tcx_mode_t   m0, m1;

    // ------------------------------------------------------------------
    // bus decode: write lands on the edge that sees ack high
    // ------------------------------------------------------------------
    logic       req, wr_en;
    logic [9:0] idx;
    logic [7:0] wdat;
    assign req   = wb_i.cyc & wb_i.stb;
    assign wr_en = req & wb_i.we & ack_q & wb_i.sel[0];
    assign idx   = wb_i.adr;
    assign wdat  = wb_i.dat[7:0];

    function automatic logic wr_at(input logic en, input logic [9:0] a,
                                   input logic [9:0] target);
        return en && (a == target);
    endfunction

    // ------------------------------------------------------------------
    // pin history for falling edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            x0_prev_q <= 1'b1;
            x1_prev_q <= 1'b1;
            c0_prev_q <= 1'b1;
            c1_prev_q <= 1'b1;
        end else begin
            x0_prev_q <= ext_irq0_pin_i;
            x1_prev_q <= ext_irq1_pin_i;
            c0_prev_q <= count_pin_zero_i;
            c1_prev_q <= count_pin_one_i;
        end
    end

    // ------------------------------------------------------------------
    // count enables and next counter values
    // ------------------------------------------------------------------
    always_comb begin
        m0 = tcx_mode_t'(timer_mode_select_q[1:0]);
        m1 = tcx_mode_t'(timer_mode_select_q[5:4]);
        // gating by the interrupt pin
        run0 = trun_q[TCX_B_TR0] & (~timer_mode_select_q[TCX_B_GATE]
               | ext_irq0_pin_i);
        run1 = trun_q[TCX_B_TR1] & (~timer_mode_select_q[4 + TCX_B_GATE]
               | ext_irq1_pin_i);
        // clock or falling edge of the count pin
        tick0 = timer_mode_select_q[TCX_B_CSEL] ? (c0_prev_q & ~count_pin_zero_i)
                                   : 1'b1;
        tick1 = timer_mode_select_q[4 + TCX_B_CSEL] ? (c1_prev_q & ~count_pin_one_i)
                                       : 1'b1;
        st0 = tcx_step(m0, tl0_q, th0_q);
        st1 = tcx_step(m1, tl1_q, th1_q);
        tl0_d   = tl0_q;
        th0_d   = th0_q;
        tl1_d   = tl1_q;
        th1_d   = th1_q;
        tf0_set = 1'b0;
        tf1_set = 1'b0;
        if (m0 == TCX_SPLIT) begin
            // low byte on timer zero controls
            if (run0 && tick0) begin
                tl0_d   = tl0_q + 8'h01;
                tf0_set = (tl0_q == 8'hff);
            end
            // high byte counts clocks under timer one run bit
            if (trun_q[TCX_B_TR1]) begin
                th0_d   = th0_q + 8'h01;
                tf1_set = (th0_q == 8'hff);
            end
        end else if (run0 && tick0) begin
            {tf0_set, th0_d, tl0_d} = st0;
        end
        // timer one keeps counting in split mode but loses its flag
        if (run1 && tick1) begin
            th1_d = st1[15:8];
            tl1_d = st1[7:0];
            if (m0 != TCX_SPLIT) begin
                tf1_set = st1[16];
            end
        end
    end

    // ------------------------------------------------------------------
    // counter registers; a software write beats a count
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tl0_q <= TCX_RST_BYTE;
            th0_q <= TCX_RST_BYTE;
            tl1_q <= TCX_RST_BYTE;
            th1_q <= TCX_RST_BYTE;
        end else begin
            tl0_q <= wr_at(wr_en, idx, TCX_IDX_TL0) ? wdat : tl0_d;
            th0_q <= wr_at(wr_en, idx, TCX_IDX_TH0) ? wdat : th0_d;
            tl1_q <= wr_at(wr_en, idx, TCX_IDX_TL1) ? wdat : tl1_d;
            th1_q <= wr_at(wr_en, idx, TCX_IDX_TH1) ? wdat : th1_d;
        end
    end

    // ------------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_mode_select_q <= TCX_RST_BYTE;
        end else if (wr_at(wr_en, idx, TCX_IDX_TIMER_MODE_SELECT)) begin
            timer_mode_select_q <= wdat;
        end
    end

    // ------------------------------------------------------------------
    // external request triggers
    // ------------------------------------------------------------------
    assign ie0_set = trun_q[TCX_B_IT0] ? (x0_prev_q & ~ext_irq0_pin_i)
                                       : ~ext_irq0_pin_i;
    assign ie1_set = trun_q[TCX_B_IT1] ? (x1_prev_q & ~ext_irq1_pin_i)
                                       : ~ext_irq1_pin_i;

    // ------------------------------------------------------------------
    // run and flag register; hardware set wins over any clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trun_q <= TCX_RST_BYTE;
        end else begin
            if (wr_at(wr_en, idx, TCX_IDX_TRUN)) begin
                trun_q <= wdat;
            end
            if (vector_ack_i[TCX_EV_T1]) begin
                trun_q[TCX_B_TF1] <= 1'b0;
            end
            if (vector_ack_i[TCX_EV_T0]) begin
                trun_q[TCX_B_TF0] <= 1'b0;
            end
            if (tf1_set) begin
                trun_q[TCX_B_TF1] <= 1'b1;
            end
            if (tf0_set) begin
                trun_q[TCX_B_TF0] <= 1'b1;
            end
            // edge mode latches; level mode mirrors the inverted pin
            if (trun_q[TCX_B_IT1]) begin
                if (vector_ack_i[TCX_EV_X1]) begin
                    trun_q[TCX_B_IE1] <= 1'b0;
                end
                if (ie1_set) begin
                    trun_q[TCX_B_IE1] <= 1'b1;
                end
            end else begin
                trun_q[TCX_B_IE1] <= ~ext_irq1_pin_i;
            end
            if (trun_q[TCX_B_IT0]) begin
                if (vector_ack_i[TCX_EV_X0]) begin
                    trun_q[TCX_B_IE0] <= 1'b0;
                end
                if (ie0_set) begin
                    trun_q[TCX_B_IE0] <= 1'b1;
                end
            end else begin
                trun_q[TCX_B_IE0] <= ~ext_irq0_pin_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // sticky event status, enable and interrupt line
    // ------------------------------------------------------------------
    assign ev = {tf1_set, ie1_set, tf0_set, ie0_set};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_q <= TCX_RST_NIB;
        end else begin
            // new event beats a clear in the same cycle
            sts_q <= (sts_q & ~({4{wr_at(wr_en, idx, TCX_IDX_ICLR)}}
                     & wdat[3:0])) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= TCX_RST_NIB;
        end else if (wr_at(wr_en, idx, TCX_IDX_IEN)) begin
            en_q <= wdat[3:0];
        end
    end

    // one cycle behind the status so the output is a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & en_q);
        end
    end

    // ------------------------------------------------------------------
    // bus answer: one wait state, unmapped reads give zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= TCX_RST_BYTE;
        end else if (req && !ack_q) begin
            unique case (idx)
                TCX_IDX_TRUN: rdat_q <= trun_q;
                TCX_IDX_TIMER_MODE_SELECT: rdat_q <= timer_mode_select_q;
                TCX_IDX_TL0:  rdat_q <= tl0_q;
                TCX_IDX_TL1:  rdat_q <= tl1_q;
                TCX_IDX_TH0:  rdat_q <= th0_q;
                TCX_IDX_TH1:  rdat_q <= th1_q;
                TCX_IDX_ISTS: rdat_q <= {4'h0, sts_q};
                TCX_IDX_IEN:  rdat_q <= {4'h0, en_q};
                default:      rdat_q <= TCX_RST_BYTE;
            endcase
        end
    end

    assign wb_o.ack  = ack_q;
    assign wb_o.dat  = {24'h00_0000, rdat_q};
    assign irq_o     = irq_q;
    assign int_req_o = {trun_q[TCX_B_TF1], trun_q[TCX_B_IE1],
                        trun_q[TCX_B_TF0], trun_q[TCX_B_IE0]};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic no_wr;
    assign no_wr = ~wr_en;

    sequence s_bus_req;
        req && !ack_q;
    endsequence
    sequence s_bus_ans;
        ack_q ##1 !ack_q;
    endsequence

    property p_tf1_set;
        tf1_set |=> trun_q[TCX_B_TF1];
    endproperty
    a_tf1_set: assert property (p_tf1_set)
        else $error("t1 flag not set on overflow");

    property p_tf1_clr;
        vector_ack_i[TCX_EV_T1] && !tf1_set && no_wr
            |=> !trun_q[TCX_B_TF1];
    endproperty
    a_tf1_clr: assert property (p_tf1_clr)
        else $error("t1 flag not cleared on vector");

    property p_tf0_set;
        tf0_set |=> trun_q[TCX_B_TF0];
    endproperty
    a_tf0_set: assert property (p_tf0_set)
        else $error("t0 flag not set on overflow");

    property p_stop0;
        !trun_q[TCX_B_TR0] && m0 != TCX_SPLIT && no_wr
            |=> $stable({th0_q, tl0_q});
    endproperty
    a_stop0: assert property (p_stop0)
        else $error("t0 counted while stopped");

    property p_edge1;
        trun_q[TCX_B_IT1] && $fell(ext_irq1_pin_i) |=> trun_q[TCX_B_IE1];
    endproperty
    a_edge1: assert property (p_edge1)
        else $error("ext1 edge not latched");

    property p_level0;
        !trun_q[TCX_B_IT0] && no_wr
            |=> trun_q[TCX_B_IE0] == !$past(ext_irq0_pin_i);
    endproperty
    a_level0: assert property (p_level0)
        else $error("ext0 level flag not following pin");

    property p_gate0;
        timer_mode_select_q[TCX_B_GATE] && !ext_irq0_pin_i && m0 != TCX_SPLIT && no_wr
            |=> $stable({th0_q, tl0_q});
    endproperty
    a_gate0: assert property (p_gate0)
        else $error("t0 counted while gated off");

    property p_reload0;
        m0 == TCX_RLD && run0 && tick0 && tl0_q == 8'hff && no_wr
            |=> tl0_q == $past(th0_q) && $stable(th0_q);
    endproperty
    a_reload0: assert property (p_reload0)
        else $error("reload value wrong");

    property p_hold1;
        m1 == TCX_SPLIT && no_wr |=> $stable({th1_q, tl1_q});
    endproperty
    a_hold1: assert property (p_hold1)
        else $error("t1 moved in mode 11");

    property p_split_hi;
        m0 == TCX_SPLIT && trun_q[TCX_B_TR1] && th0_q == 8'hff && no_wr
            |=> trun_q[TCX_B_TF1] && th0_q == 8'h00;
    endproperty
    a_split_hi: assert property (p_split_hi)
        else $error("split high byte overflow missed");

    property p_bus;
        s_bus_req |=> s_bus_ans;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus answer timing wrong");

endmodule

/* pkg/tcx_pkg.sv */
// constants, types and register map of the dual timer/counter block
package tcx_pkg;

    // ------------------------------------------------------------------
    // register word indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] TCX_IDX_TRUN = 10'h088; // run and flag register
    localparam logic [9:0] TCX_IDX_TIMER_MODE_SELECT = 10'h089; // timer mode select
    localparam logic [9:0] TCX_IDX_TL0  = 10'h08a;
    localparam logic [9:0] TCX_IDX_TL1  = 10'h08b;
    localparam logic [9:0] TCX_IDX_TH0  = 10'h08c;
    localparam logic [9:0] TCX_IDX_TH1  = 10'h08d;
    localparam logic [9:0] TCX_IDX_ISTS = 10'h090; // sticky status, ro
    localparam logic [9:0] TCX_IDX_ICLR = 10'h091; // clear, wo
    localparam logic [9:0] TCX_IDX_IEN  = 10'h092; // enable, rw

    // ------------------------------------------------------------------
    // bit positions of the run and flag register
    // ------------------------------------------------------------------
    localparam int TCX_B_TF1 = 7;
    localparam int TCX_B_TR1 = 6;
    localparam int TCX_B_TF0 = 5;
    localparam int TCX_B_TR0 = 4;
    localparam int TCX_B_IE1 = 3;
    localparam int TCX_B_IT1 = 2;
    localparam int TCX_B_IE0 = 1;
    localparam int TCX_B_IT0 = 0;

    // mode register: timer one in the upper nibble, timer zero lower
    localparam int TCX_B_GATE = 3;
    localparam int TCX_B_CSEL = 2;

    // event / vector order: ext0, t0, ext1, t1
    localparam int TCX_EV_X0 = 0;
    localparam int TCX_EV_T0 = 1;
    localparam int TCX_EV_X1 = 2;
    localparam int TCX_EV_T1 = 3;

    // values after reset
    localparam logic [7:0] TCX_RST_BYTE = 8'h00;
    localparam logic [3:0] TCX_RST_NIB  = 4'h0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TCX_M13   = 2'b00,
        TCX_M16   = 2'b01,
        TCX_RLD   = 2'b10,
        TCX_SPLIT = 2'b11
    } tcx_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:2] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tcx_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } tcx_wb_rsp_t;

endpackage

/* tb/tcx_pin_model.sv */
// model of the external count pins and interrupt pins of the timer block
`timescale 1ns/1ps
module tcx_pin_model (
    // clock
    input  wire logic clk_i,
    // pins toward the block, idle high like pulled-up inputs
    output logic      ext_irq0_pin_o,
    output logic      ext_irq1_pin_o,
    output logic      count_pin_zero_o,
    output logic      count_pin_one_o
);
    // pins start high so no false edge is seen after reset
    initial begin
        ext_irq0_pin_o   = 1'b1;
        ext_irq1_pin_o   = 1'b1;
        count_pin_zero_o = 1'b1;
        count_pin_one_o  = 1'b1;
    end

    // ------------------------------------------------------------------
    // interrupt pin level, changed just after a clock edge
    // ------------------------------------------------------------------
    task automatic set_irq(input int ch, input logic lv);
        @(posedge clk_i);
        if (ch == 0) begin
            ext_irq0_pin_o <= lv;
        end else begin
            ext_irq1_pin_o <= lv;
        end
    endtask

    // ------------------------------------------------------------------
    // n falling edges, each low and high for one full clock
    // ------------------------------------------------------------------
    task automatic count_fall(input int ch, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (ch == 0) count_pin_zero_o <= 1'b0;
            else count_pin_one_o <= 1'b0;
            @(posedge clk_i);
            if (ch == 0) count_pin_zero_o <= 1'b1;
            else count_pin_one_o <= 1'b1;
        end
    endtask
endmodule

/* tb/tcx_timer_ctrl_tb.sv */
// self-checking testbench of the dual timer/counter block
`timescale 1ns/1ps
module tcx_timer_ctrl_tb import tcx_pkg::*;;
    logic        clk_i;
    logic        rst_i;
    tcx_wb_req_t wb_i;
    tcx_wb_rsp_t wb_o;
    logic        irq0_pin, irq1_pin, cnt0_pin, cnt1_pin;
    logic [3:0]  vector_ack;
    logic [3:0]  int_req;
    logic        irq;
    logic [31:0] rdat;
    int          err_count;
    int          compares;

    // ------------------------------------------------------------------
    // design and pin model
    // ------------------------------------------------------------------
    tcx_timer_ctrl tcx_timer_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
        .ext_irq0_pin_i(irq0_pin), .ext_irq1_pin_i(irq1_pin),
        .count_pin_zero_i(cnt0_pin), .count_pin_one_i(cnt1_pin),
        .vector_ack_i(vector_ack), .int_req_o(int_req), .irq_o(irq)
    );
    tcx_pin_model tcx_pin_model_i (
        .clk_i(clk_i), .ext_irq0_pin_o(irq0_pin),
        .ext_irq1_pin_o(irq1_pin), .count_pin_zero_o(cnt0_pin),
        .count_pin_one_o(cnt1_pin)
    );

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // bus, compare and closing tasks
    // ------------------------------------------------------------------
    // single classic cycle; idle cycle follows so stb never re-fires
    task automatic xfer(input logic w, input logic [9:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1,
                  dat: {24'h00_0000, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_o.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("[ERR] t=%0t bus answer missing", $time);
        end
        rdat = wb_o.dat;
        wb_i <= '0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(rdat, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one-cycle vectoring pulse
    task automatic vec(input int b);
        @(posedge clk_i);
        vector_ack <= 4'h1 << b;
        @(posedge clk_i);
        vector_ack <= 4'h0;
    endtask

    task automatic test_end(input string name);
        $display("test %s done, errors so far %0d", name, err_count);
    endtask

    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog: the tests need a few thousand cycles at most
    initial begin
        #300000;
        err_count++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst_i      = 1'b1;
        wb_i       = '0;
        vector_ack = 4'h0;
        err_count  = 0;
        compares   = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset state, unmapped place reads zero
        rdchk(TCX_IDX_TRUN, 32'h0000_0000);
        rdchk(TCX_IDX_TIMER_MODE_SELECT, 32'h0000_0000);
        rdchk(TCX_IDX_ISTS, 32'h0000_0000);
        rdchk(10'h0ff, 32'h0000_0000);
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'ha5);
        rdchk(TCX_IDX_TIMER_MODE_SELECT, 32'h0000_00a5);
        chk({31'h0, irq}, 32'h0000_0000);
        test_end("registers");
        // 16-bit timer zero wraps, flag and interrupt path
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h01);
        wr(TCX_IDX_TL0, 8'hfe);
        wr(TCX_IDX_TH0, 8'hff);
        wr(TCX_IDX_TRUN, 8'h10);
        idle(6);
        rdchk(TCX_IDX_TRUN, 32'h0000_0030);
        rdchk(TCX_IDX_TH0, 32'h0000_0000);
        wr(TCX_IDX_IEN, 8'h02);
        idle(2);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({31'h0, int_req[1]}, 32'h0000_0001);
        vec(TCX_EV_T0);
        rdchk(TCX_IDX_TRUN, 32'h0000_0010);
        wr(TCX_IDX_TRUN, 8'h00);
        wr(TCX_IDX_IEN, 8'h00);
        idle(2);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(TCX_IDX_IEN, 8'h02);
        wr(TCX_IDX_ISTS, 8'hff);
        rdchk(TCX_IDX_ISTS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(TCX_IDX_ICLR, 8'h02);
        idle(2);
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(TCX_IDX_ISTS, 32'h0000_0000);
        wr(TCX_IDX_IEN, 8'h00);
        test_end("mode 01 and interrupt");
        // 13-bit: prescaler carries into high byte, tl0[7:5] kept
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h00);
        wr(TCX_IDX_TL0, 8'hff);
        wr(TCX_IDX_TH0, 8'h00);
        wr(TCX_IDX_TRUN, 8'h10);
        idle(4);
        wr(TCX_IDX_TRUN, 8'h00);
        rdchk(TCX_IDX_TH0, 32'h0000_0001);
        chk(rdat & 32'h0000_00e0, 32'h0000_0000);
        xfer(1'b0, TCX_IDX_TL0, 8'h00);
        chk(rdat & 32'h0000_00e0, 32'h0000_00e0);
        test_end("mode 00");
        // auto-reload: low byte stays within reload range
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h02);
        wr(TCX_IDX_TH0, 8'hf0);
        wr(TCX_IDX_TL0, 8'hfe);
        wr(TCX_IDX_TRUN, 8'h10);
        idle(5);
        rdchk(TCX_IDX_TRUN, 32'h0000_0030);
        wr(TCX_IDX_TRUN, 8'h00);
        rdchk(TCX_IDX_TH0, 32'h0000_00f0);
        xfer(1'b0, TCX_IDX_TL0, 8'h00);
        chk(rdat & 32'h0000_00f0, 32'h0000_00f0);
        test_end("mode 10");
        // split timer zero: both halves wrap, each sets its own flag
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h03);
        wr(TCX_IDX_TL0, 8'hfe);
        wr(TCX_IDX_TH0, 8'hfe);
        wr(TCX_IDX_TRUN, 8'h50);
        idle(4);
        rdchk(TCX_IDX_TRUN, 32'h0000_00f0);
        test_end("split");
        // timer one: wrap flag, vector clear, software set, mode 11 hold
        wr(TCX_IDX_TRUN, 8'h00);
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h10);
        wr(TCX_IDX_TL1, 8'hfe);
        wr(TCX_IDX_TH1, 8'hff);
        wr(TCX_IDX_TRUN, 8'h40);
        idle(4);
        rdchk(TCX_IDX_TRUN, 32'h0000_00c0);
        chk({31'h0, int_req[3]}, 32'h0000_0001);
        vec(TCX_EV_T1);
        rdchk(TCX_IDX_TRUN, 32'h0000_0040);
        wr(TCX_IDX_TRUN, 8'h80);
        rdchk(TCX_IDX_TRUN, 32'h0000_0080);
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h30);
        wr(TCX_IDX_TL1, 8'h55);
        wr(TCX_IDX_TRUN, 8'h40);
        idle(6);
        rdchk(TCX_IDX_TL1, 32'h0000_0055);
        test_end("timer one");
        // gating: pin low blocks counting, pin high lets it run
        wr(TCX_IDX_TRUN, 8'h00);
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h09);
        wr(TCX_IDX_TL0, 8'h00);
        tcx_pin_model_i.set_irq(0, 1'b0);
        wr(TCX_IDX_TRUN, 8'h10);
        idle(5);
        rdchk(TCX_IDX_TL0, 32'h0000_0000);
        tcx_pin_model_i.set_irq(0, 1'b1);
        idle(5);
        wr(TCX_IDX_TRUN, 8'h00);
        xfer(1'b0, TCX_IDX_TL0, 8'h00);
        chk({31'h0, rdat == 32'h0}, 32'h0000_0000);
        test_end("gating");
        // counter select: only pin falls are counted, both timers
        wr(TCX_IDX_TIMER_MODE_SELECT, 8'h55);
        wr(TCX_IDX_TL0, 8'h00);
        wr(TCX_IDX_TL1, 8'h00);
        wr(TCX_IDX_TRUN, 8'h50);
        tcx_pin_model_i.count_fall(0, 3);
        tcx_pin_model_i.count_fall(1, 2);
        wr(TCX_IDX_TRUN, 8'h00);
        rdchk(TCX_IDX_TL0, 32'h0000_0003);
        rdchk(TCX_IDX_TL1, 32'h0000_0002);
        test_end("counter");
        // external requests: edge latches until vectored, level tracks
        for (int ch = 0; ch < 2; ch++) begin
            wr(TCX_IDX_TRUN, 8'h05);
            tcx_pin_model_i.set_irq(ch, 1'b0);
            tcx_pin_model_i.set_irq(ch, 1'b1);
            idle(2);
            rdchk(TCX_IDX_TRUN, ch ? 32'h0000_000d : 32'h0000_0007);
            vec(ch ? TCX_EV_X1 : TCX_EV_X0);
            rdchk(TCX_IDX_TRUN, 32'h0000_0005);
            wr(TCX_IDX_TRUN, 8'h00);
            tcx_pin_model_i.set_irq(ch, 1'b0);
            idle(2);
            chk({31'h0, int_req[2*ch]}, 32'h0000_0001);
            vec(ch ? TCX_EV_X1 : TCX_EV_X0);
            idle(2);
            chk({31'h0, int_req[2*ch]}, 32'h0000_0001);
            tcx_pin_model_i.set_irq(ch, 1'b1);
            idle(2);
            chk({31'h0, int_req[2*ch]}, 32'h0000_0000);
        end
        test_end("external requests");
        print_verdict();
    end
endmodule
